// ==== ascii_cmd_pkg.sv ====
// Constants, carriers and states shared by the ASCII command parser
`default_nettype none
package ascii_cmd_pkg;
  // ****************************************
  // Characters
  // ****************************************
  localparam logic [7:0] CH_AT    = 8'h40;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_2     = 8'h32;
  localparam logic [7:0] CH_3     = 8'h33;
  localparam logic [7:0] CH_5     = 8'h35;
  localparam logic [7:0] CH_6     = 8'h36;
  localparam logic [7:0] CH_7     = 8'h37;
  localparam logic [7:0] CH_8     = 8'h38;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_B     = 8'h42;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_U     = 8'h55;
  localparam logic [7:0] CH_LOW_E = 8'h65;
  // ****************************************
  // Message layout (index of each body character after the at-sign)
  // ****************************************
  localparam logic [3:0] IDX_CAT_A = 4'h0;
  localparam logic [3:0] IDX_CAT_B = 4'h1;
  localparam logic [3:0] IDX_NUM   = 4'h2;
  localparam logic [3:0] IDX_PARAM = 4'h3;
  localparam logic [3:0] IDX_COLON = 4'h4;
  localparam logic [3:0] IDX_DATA  = 4'h5;
  localparam logic [3:0] LEN_ONE   = 4'h6;
  localparam logic [3:0] IDX_MAX   = 4'hf;
  // ****************************************
  // Register map and bus answers
  // ****************************************
  localparam logic [7:0] OFS_SETTINGS = 8'h00;
  localparam logic [7:0] OFS_LEAK     = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int BIT_ALARM = 0;
  localparam int BIT_LOCK  = 1;
  localparam int BIT_UNITS = 2;
  localparam int BIT_CKSUM = 4;
  localparam int BIT_SCI   = 5;
  localparam int BIT_WORD8 = 6;
  localparam logic [1:0] UNITS_TORR   = 2'h0;
  localparam logic [1:0] UNITS_PASCAL = 2'h1;
  localparam logic [1:0] UNITS_MBAR   = 2'h2;
  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic [15:0] leak;
    logic        word8;
    logic        sci;
    logic        cksum;
    logic [1:0]  units;
    logic        lock;
    logic        alarm;
  } settings_t;
  localparam settings_t SETTINGS_RESET = '{leak: 16'h0001, word8: 1'b1, sci: 1'b0,
    cksum: 1'b0, units: UNITS_TORR, lock: 1'b0, alarm: 1'b1};
  typedef struct packed {
    logic [7:0]      status;
    logic [3:0][7:0] text;
  } meas_t;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_BODY = 3'b001,
    P_CKLO = 3'b010,
    P_CKHI = 3'b011,
    P_EXEC = 3'b100,
    P_SEND = 3'b101
  } parse_state_t;
endpackage
`default_nettype wire

// ==== ascii_serial_command_parser.sv ====
// ASCII serial command parser with settings, queries and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`default_nettype none
module ascii_serial_command_parser (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_data,
  output var  logic                      tx_valid,
  output var  logic [7:0]                tx_data,
  input  wire logic                      tx_ready,
  input  wire logic                      panel_exit,
  input  wire logic                      displayless_pin,
  input  wire ascii_cmd_pkg::meas_t      meas,
  output var  ascii_cmd_pkg::settings_t  settings,
  output var  logic                      nv_save,
  input  wire logic                      awvalid,
  output var  logic                      awready,
  input  wire logic [7:0]                awaddr,
  input  wire logic                      wvalid,
  output var  logic                      wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  output var  logic                      bvalid,
  input  wire logic                      bready,
  output var  logic [1:0]                bresp,
  input  wire logic                      arvalid,
  output var  logic                      arready,
  input  wire logic [7:0]                araddr,
  output var  logic                      rvalid,
  input  wire logic                      rready,
  output var  logic [31:0]               rdata,
  output var  logic [1:0]                rresp
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ascii_cmd_pkg::parse_state_t pstate;
    logic [3:0]                  idx;
    logic [15:0]                 sum;
    logic [7:0]                  cat_a;
    logic [7:0]                  cat_b;
    logic [7:0]                  num;
    logic [7:0]                  param;
    logic [7:0]                  colon;
    logic [7:0]                  data0;
    logic [15:0]                 acc;
    logic                        acc_ok;
    logic                        acc_stop;
    logic                        acc_bad;
    logic [7:0]                  ck_lo;
    ascii_cmd_pkg::settings_t    set;
    logic [2:0]                  disp_sync;
    logic                        displayless;
    logic                        nv_save;
    logic [15:0][7:0]            txbuf;
    logic [4:0]                  txlen;
    logic [4:0]                  txpos;
    logic                        tx_ck;
    logic [15:0]                 tx_sum;
    logic                        tx_valid;
    logic [7:0]                  tx_data;
    logic [7:0]                  good_cnt;
    logic [7:0]                  bad_cnt;
    logic                        aw_got;
    logic                        w_got;
    logic [7:0]                  awaddr;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= ascii_cmd_pkg::CH_0) && (c <= ascii_cmd_pkg::CH_9);
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_bytes = r;
  endfunction

  function automatic logic [31:0] flag_word(input ascii_cmd_pkg::settings_t st);
    flag_word = {25'h0000000, st.word8, st.sci, st.cksum, st.units, st.lock, st.alarm};
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0]  dig;
    logic [4:0]  p;
    logic        one_data;
    logic        is_chan_q;
    logic        q_ok;
    logic        ok;
    logic [31:0] tmp;
    next_s = s;
    dig = 8'h00;
    p = 5'h00;
    one_data = 1'b0;
    is_chan_q = 1'b0;
    q_ok = 1'b0;
    ok = 1'b0;
    tmp = 32'h00000000;
    next_s.nv_save = panel_exit;
    // Strap filter: only the last two stages are compared
    next_s.disp_sync = {s.disp_sync[1:0], displayless_pin};
    if (s.disp_sync[2] == s.disp_sync[1]) begin
      next_s.displayless = s.disp_sync[2];
    end

    // ****************************************
    // Receive and parse
    // ****************************************
    case (s.pstate)
      ascii_cmd_pkg::P_IDLE, ascii_cmd_pkg::P_BODY: begin
        if (rx_valid && rx_data == ascii_cmd_pkg::CH_AT) begin
          next_s.pstate = ascii_cmd_pkg::P_BODY;
          next_s.idx = 4'h0;
          next_s.sum = {8'h00, rx_data};
          next_s.acc = 16'h0000;
          next_s.acc_ok = 1'b0;
          next_s.acc_stop = 1'b0;
          next_s.acc_bad = 1'b0;
        end else if (rx_valid && s.pstate == ascii_cmd_pkg::P_BODY) begin
          next_s.sum = 16'(s.sum + {8'h00, rx_data});
          if (rx_data == ascii_cmd_pkg::CH_CR) begin
            // The enable message never carries checksum bytes
            if (s.set.cksum && !(s.cat_a == ascii_cmd_pkg::CH_5 &&
                s.cat_b == ascii_cmd_pkg::CH_0 && s.num == ascii_cmd_pkg::CH_5)) begin
              next_s.pstate = ascii_cmd_pkg::P_CKLO;
            end else begin
              next_s.pstate = ascii_cmd_pkg::P_EXEC;
            end
          end else begin
            case (s.idx)
              ascii_cmd_pkg::IDX_CAT_A: next_s.cat_a = rx_data;
              ascii_cmd_pkg::IDX_CAT_B: next_s.cat_b = rx_data;
              ascii_cmd_pkg::IDX_NUM:   next_s.num = rx_data;
              ascii_cmd_pkg::IDX_PARAM: next_s.param = rx_data;
              ascii_cmd_pkg::IDX_COLON: next_s.colon = rx_data;
              default: begin
              end
            endcase
            if (s.idx == ascii_cmd_pkg::IDX_DATA) begin
              next_s.data0 = rx_data;
            end
            // Numeric data: integer part of a fixed value or of a scientific mantissa; the exponent is ignored
            if (s.idx >= ascii_cmd_pkg::IDX_DATA) begin
              dig = rx_data - ascii_cmd_pkg::CH_0;
              if (is_digit(rx_data)) begin
                if (!s.acc_stop) begin
                  next_s.acc = 16'(s.acc * 16'h000a + {8'h00, dig});
                  next_s.acc_ok = 1'b1;
                end
              end else if (rx_data == ascii_cmd_pkg::CH_DOT ||
                           rx_data == ascii_cmd_pkg::CH_E ||
                           rx_data == ascii_cmd_pkg::CH_LOW_E ||
                           rx_data == ascii_cmd_pkg::CH_PLUS ||
                           rx_data == ascii_cmd_pkg::CH_MINUS) begin
                next_s.acc_stop = 1'b1;
              end else begin
                next_s.acc_bad = 1'b1;
              end
            end
            if (s.idx != ascii_cmd_pkg::IDX_MAX) begin
              next_s.idx = s.idx + 4'h1;
            end
          end
        end
      end
      ascii_cmd_pkg::P_CKLO: begin
        if (rx_valid) begin
          next_s.ck_lo = rx_data;
          next_s.pstate = ascii_cmd_pkg::P_CKHI;
        end
      end
      ascii_cmd_pkg::P_CKHI: begin
        if (rx_valid) begin
          if ({rx_data, s.ck_lo} == s.sum) begin
            next_s.pstate = ascii_cmd_pkg::P_EXEC;
          end else begin
            next_s.pstate = ascii_cmd_pkg::P_IDLE;
            next_s.bad_cnt = s.bad_cnt + 8'h01;
          end
        end
      end
      ascii_cmd_pkg::P_EXEC: begin
        next_s.pstate = ascii_cmd_pkg::P_IDLE;
        one_data = (s.idx == ascii_cmd_pkg::LEN_ONE) && (s.colon == ascii_cmd_pkg::CH_COLON);
        if (s.cat_a == ascii_cmd_pkg::CH_5 && s.cat_b == ascii_cmd_pkg::CH_0) begin
          case (s.num)
            ascii_cmd_pkg::CH_1, ascii_cmd_pkg::CH_5, ascii_cmd_pkg::CH_8: begin
              if (one_data && (s.data0 == ascii_cmd_pkg::CH_E ||
                               s.data0 == ascii_cmd_pkg::CH_D)) begin
                ok = 1'b1;
                if (s.num == ascii_cmd_pkg::CH_1) begin
                  next_s.set.alarm = (s.data0 == ascii_cmd_pkg::CH_E);
                end else if (s.num == ascii_cmd_pkg::CH_5) begin
                  next_s.set.cksum = (s.data0 == ascii_cmd_pkg::CH_E);
                end else begin
                  next_s.set.sci = (s.data0 == ascii_cmd_pkg::CH_E);
                end
              end
            end
            ascii_cmd_pkg::CH_2: begin
              if (one_data && (s.data0 == ascii_cmd_pkg::CH_U ||
                               s.data0 == ascii_cmd_pkg::CH_L)) begin
                ok = 1'b1;
                next_s.set.lock = (s.data0 == ascii_cmd_pkg::CH_L);
              end
            end
            ascii_cmd_pkg::CH_3: begin
              ok = one_data;
              if (one_data && s.data0 == ascii_cmd_pkg::CH_T) begin
                next_s.set.units = ascii_cmd_pkg::UNITS_TORR;
              end else if (one_data && s.data0 == ascii_cmd_pkg::CH_P) begin
                next_s.set.units = ascii_cmd_pkg::UNITS_PASCAL;
              end else if (one_data && s.data0 == ascii_cmd_pkg::CH_B) begin
                next_s.set.units = ascii_cmd_pkg::UNITS_MBAR;
              end else begin
                ok = 1'b0;
              end
            end
            ascii_cmd_pkg::CH_6: begin
              if (s.idx == ascii_cmd_pkg::IDX_COLON) begin
                ok = 1'b1;
                next_s.nv_save = 1'b1;
              end
            end
            ascii_cmd_pkg::CH_7: begin
              if (s.colon == ascii_cmd_pkg::CH_COLON && s.acc_ok && !s.acc_bad &&
                  s.idx != ascii_cmd_pkg::IDX_MAX) begin
                ok = 1'b1;
                next_s.set.leak = s.acc;
              end
            end
            default: begin
            end
          endcase
        end else if (s.cat_a == ascii_cmd_pkg::CH_6 && s.cat_b == ascii_cmd_pkg::CH_0 &&
                     s.idx == ascii_cmd_pkg::IDX_DATA &&
                     s.colon == ascii_cmd_pkg::CH_QUERY) begin
          is_chan_q = (s.num >= ascii_cmd_pkg::CH_1 && s.num <= ascii_cmd_pkg::CH_6) ||
                      s.num == ascii_cmd_pkg::CH_8;
          q_ok = is_chan_q ? (s.param >= ascii_cmd_pkg::CH_1 &&
                              s.param <= ascii_cmd_pkg::CH_6)
                           : (s.num == ascii_cmd_pkg::CH_7 || s.num == ascii_cmd_pkg::CH_9);
          // Only the reply is built; no setting is touched
          if (q_ok) begin
            ok = 1'b1;
            next_s.txbuf[0] = ascii_cmd_pkg::CH_AT;
            next_s.txbuf[1] = s.cat_a;
            next_s.txbuf[2] = s.cat_b;
            next_s.txbuf[3] = s.num;
            p = 5'h04;
            if (is_chan_q) begin
              next_s.txbuf[4] = s.param;
              p = 5'h05;
            end
            next_s.txbuf[p[3:0]] = ascii_cmd_pkg::CH_COLON;
            next_s.txbuf[4'(p + 5'h01)] = meas.status;
            for (int i = 0; i < 4; i++) begin
              next_s.txbuf[4'(p + 5'h02 + 5'(i))] = meas.text[i];
            end
            next_s.txbuf[4'(p + 5'h06)] = ascii_cmd_pkg::CH_CR;
            next_s.txlen = 5'(p + 5'h07);
            next_s.txpos = 5'h00;
            next_s.tx_sum = 16'h0000;
            next_s.tx_ck = s.set.cksum;
            next_s.pstate = ascii_cmd_pkg::P_SEND;
          end
        end
        if (ok) begin
          next_s.good_cnt = s.good_cnt + 8'h01;
        end else begin
          next_s.bad_cnt = s.bad_cnt + 8'h01;
        end
      end
      ascii_cmd_pkg::P_SEND: begin
        // Characters received while replying are dropped
        if (!s.tx_valid || tx_ready) begin
          next_s.tx_valid = 1'b1;
          next_s.txpos = s.txpos + 5'h01;
          if (s.txpos < s.txlen) begin
            next_s.tx_data = s.txbuf[s.txpos[3:0]];
            next_s.tx_sum = 16'(s.tx_sum + {8'h00, s.txbuf[s.txpos[3:0]]});
          end else if (s.tx_ck && s.txpos == s.txlen) begin
            next_s.tx_data = s.tx_sum[7:0];
          end else if (s.tx_ck && s.txpos == 5'(s.txlen + 5'h01)) begin
            next_s.tx_data = s.tx_sum[15:8];
          end else begin
            next_s.tx_valid = 1'b0;
            next_s.pstate = ascii_cmd_pkg::P_IDLE;
          end
        end
      end
      default: next_s.pstate = ascii_cmd_pkg::P_IDLE;
    endcase

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = ascii_cmd_pkg::RESP_OKAY;
      case (s.awaddr)
        ascii_cmd_pkg::OFS_SETTINGS: begin
          tmp = merge_bytes(flag_word(next_s.set), s.wdata, s.wstrb);
          next_s.set.alarm = tmp[ascii_cmd_pkg::BIT_ALARM];
          next_s.set.lock = tmp[ascii_cmd_pkg::BIT_LOCK];
          next_s.set.units = tmp[ascii_cmd_pkg::BIT_UNITS +: 2];
          next_s.set.cksum = tmp[ascii_cmd_pkg::BIT_CKSUM];
          next_s.set.sci = tmp[ascii_cmd_pkg::BIT_SCI];
          if (!s.displayless) begin
            next_s.set.word8 = tmp[ascii_cmd_pkg::BIT_WORD8];
          end
        end
        ascii_cmd_pkg::OFS_LEAK: begin
          tmp = merge_bytes({16'h0000, next_s.set.leak}, s.wdata, s.wstrb);
          next_s.set.leak = tmp[15:0];
        end
        ascii_cmd_pkg::OFS_STATUS: begin
        end
        default: next_s.bresp = ascii_cmd_pkg::RESP_SLVERR;
      endcase
    end
    if (s.displayless) begin
      next_s.set.word8 = ascii_cmd_pkg::SETTINGS_RESET.word8;
    end
    next_s.set.word8 = next_s.set.word8 | next_s.set.cksum;
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = ascii_cmd_pkg::RESP_OKAY;
      case (araddr)
        ascii_cmd_pkg::OFS_SETTINGS: next_s.rdata = flag_word(s.set);
        ascii_cmd_pkg::OFS_LEAK:     next_s.rdata = {16'h0000, s.set.leak};
        ascii_cmd_pkg::OFS_STATUS: begin
          next_s.rdata = {12'h000, s.displayless, s.pstate, s.bad_cnt, s.good_cnt};
        end
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = ascii_cmd_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
      s.set <= ascii_cmd_pkg::SETTINGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign tx_valid = s.tx_valid;
  assign tx_data  = s.tx_data;
  assign settings = s.set;
  assign nv_save  = s.nv_save;
  assign awready  = s.awready;
  assign wready   = s.wready;
  assign bvalid   = s.bvalid;
  assign bresp    = s.bresp;
  assign arready  = s.arready;
  assign rvalid   = s.rvalid;
  assign rdata    = s.rdata;
  assign rresp    = s.rresp;
endmodule
`default_nettype wire

// ==== ascii_serial_command_parser_checker.sv ====
// Concurrent checks on the parser's ports
`default_nettype none
module ascii_serial_command_parser_checker (
  input wire logic                     clock,
  input wire logic                     rst_b,
  input wire logic                     tx_valid,
  input wire logic [7:0]               tx_data,
  input wire logic                     tx_ready,
  input wire logic                     panel_exit,
  input wire ascii_cmd_pkg::settings_t settings,
  input wire logic                     nv_save,
  input wire logic                     awready,
  input wire logic                     wready,
  input wire logic                     bvalid,
  input wire logic                     arready,
  input wire logic                     rvalid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_reset_cfg; $rose(rst_b) |-> !settings.cksum && !settings.sci; endproperty
  property p_word8; settings.cksum |-> settings.word8; endproperty
  property p_save_exit; panel_exit |-> ##[1:2] nv_save; endproperty
  property p_save_pulse; nv_save |=> !nv_save; endproperty
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  property p_aw_busy; bvalid |-> !awready && !wready; endproperty
  property p_ar_busy; rvalid |-> !arready; endproperty
  property p_cfg_quiet; tx_valid |=> bvalid || $stable(settings); endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("settings not reset");
  a_word8: assert property (p_word8) else $error("checksum on with 7-bit words");
  a_save_exit: assert property (p_save_exit) else $error("no save on panel exit");
  a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
  a_tx_hold: assert property (p_tx_hold) else $error("reply char dropped");
  a_aw_busy: assert property (p_aw_busy) else $error("write taken during response");
  a_ar_busy: assert property (p_ar_busy) else $error("read taken during response");
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("query changed settings");
  c_save: cover property (nv_save);
  c_reply: cover property (tx_valid && tx_ready);
  c_cksum: cover property (settings.cksum);
endmodule
`default_nettype wire

// ==== serial_host_model.sv ====
// Host computer model: sends ASCII messages and collects replies
`default_nettype none
module serial_host_model (
  input  wire logic       clock,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output var  logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  bit         slow = 1'b0;
  initial {rx_valid, rx_data, tx_ready} = 10'h000;
  // Slow host accepts every other cycle
  always @(posedge clock) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic put(input logic [7:0] c);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= c;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~c;
  endtask
  task automatic send(input string s, input bit ck);
    logic [15:0] sum;
    sum = 16'h0000;
    foreach (s[i]) begin
      put(s[i]);
      sum += {8'h00, s[i]};
    end
    if (ck) begin
      put(sum[7:0]);
      put(sum[15:8]);
    end
  endtask
endmodule
`default_nettype wire

// ==== ascii_serial_command_parser_test.sv ====
// Self-checking bench for the ASCII command parser
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module ascii_serial_command_parser_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, panel_exit = 0, displayless_pin = 0, awvalid = 0, wvalid = 0;
  logic bready = 0, arvalid = 0, rready = 0, rx_valid, tx_valid, tx_ready, nv_save;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0]  rx_data, tx_data, awaddr = 8'h00, araddr = 8'h00;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] wdata = 32'h0, rdata, d;
  ascii_cmd_pkg::meas_t     meas = {8'h41, 32'h34333231};
  ascii_cmd_pkg::settings_t settings, keep;
  int n_fail = 0, compares = 0, n_save = 0;
  string m, u = "BPT";
  always #4 clock = ~clock;
  always @(posedge clock) if (nv_save === 1'b1) n_save++;
  ascii_serial_command_parser DUT (.clock, .rst_b, .rx_valid, .rx_data, .tx_valid, .tx_data,
    .tx_ready, .panel_exit, .displayless_pin, .meas, .settings, .nv_save, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp);
  serial_host_model host (.clock, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp; bready <= 1'b0; @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata; r = rresp; rready <= 1'b0; @(posedge clock);
  endtask
  task automatic msg(input string s, input bit ck = 0);
    host.send(s, ck);
    repeat (6) @(posedge clock);
  endtask
  task automatic reply(input string s, input bit ck);
    logic [7:0]  q[$];
    logic [15:0] sum;
    sum = 16'h0000;
    foreach (s[i]) begin q.push_back(s[i]); sum += {8'h00, s[i]}; end
    if (ck) q = {q, sum[7:0], sum[15:8]};
    for (int i = 0; i < 400 && host.got.size() < q.size(); i++) @(posedge clock);
    repeat (4) @(posedge clock);
    `CHK("reply length", q.size(), host.got.size())
    foreach (q[i]) `CHK("reply char", q[i], host.got[i])
    host.got.delete();
  endtask
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("cksum", 1'b0, settings.cksum)
    `CHK("sci", 1'b0, settings.sci)
    msg("@501x:D\r"); `CHK("alarm", 1'b0, settings.alarm)
    msg("@502x:L\r"); `CHK("lock", 1'b1, settings.lock)
    m = "@503x:B\r";
    foreach (u[i]) begin
      m[6] = u[i];
      msg(m); `CHK("units", 2'(2 - i), settings.units)
    end
    msg("@507x:25\r"); `CHK("leak", 16'd25, settings.leak)
    msg("@507x:4.0E+0\r"); `CHK("leak", 16'd4, settings.leak)
    keep = settings;
    msg("@509x:E\r"); msg("@501x:Q\r"); `CHK("settings", keep, settings)
    msg("@508 :E\r"); `CHK("sci", 1'b1, settings.sci)
    msg("@506x\r"); `CHK("saves", 1, n_save)
    panel_exit <= 1'b1; @(posedge clock); panel_exit <= 1'b0;
    repeat (4) @(posedge clock); `CHK("saves", 2, n_save)
    host.slow = 1'b1; keep = settings;
    host.send("@6083?\r", 1'b0); reply("@6083:A1234\r", 1'b0);
    host.send("@6079?\r", 1'b0); reply("@607:A1234\r", 1'b0);
    `CHK("settings", keep, settings)
    msg("@505x:E\r"); `CHK("cksum", 1'b1, settings.cksum)
    `CHK("word8", 1'b1, settings.word8)
    msg("@501x:E\r", 1'b1); `CHK("alarm", 1'b1, settings.alarm)
    host.send("@6085?\r", 1'b1); reply("@6085:A1234\r", 1'b1);
    msg("@505x:D\r"); `CHK("cksum", 1'b0, settings.cksum)
    wr(8'h04, 32'h00000123); `CHK("bresp", 2'h0, r)
    rd(8'h04); `CHK("leak", 32'h00000123, d)
    rd(8'h00); `CHK("settings", 32'h00000063, d)
    rd(8'h10); `CHK("rresp", 2'h2, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h08, 32'hffffffff); `CHK("bresp", 2'h0, r)
    wr(8'h10, 32'h00000000); `CHK("bresp", 2'h2, r)
    wr(8'h00, 32'h00000033); rd(8'h00); `CHK("settings", 32'h00000073, d)
    wr(8'h00, 32'h00000023); rd(8'h00); `CHK("settings", 32'h00000023, d)
    displayless_pin <= 1'b1; repeat (6) @(posedge clock);
    wr(8'h00, 32'h00000023); rd(8'h00); `CHK("settings", 32'h00000063, d)
    rst_b <= 1'b0; repeat (2) @(posedge clock); rst_b <= 1'b1; repeat (2) @(posedge clock);
    `CHK("sci", 1'b0, settings.sci)
    wrap_up();
  end
endmodule
bind ascii_serial_command_parser ascii_serial_command_parser_checker chk (.clock, .rst_b,
  .tx_valid, .tx_data, .tx_ready, .panel_exit, .settings, .nv_save, .awready, .wready,
  .bvalid, .arready, .rvalid);
`default_nettype wire
